// ### core/timer8_pkg.sv
package timer8_pkg;
  // register offsets on the plain register port
  localparam logic [2:0] ADDR_CTRL_A = 3'h0;
  localparam logic [2:0] ADDR_CTRL_B = 3'h1;
  localparam logic [2:0] ADDR_COUNT = 3'h2;
  localparam logic [2:0] ADDR_CMP_A = 3'h3;
  localparam logic [2:0] ADDR_CMP_B = 3'h4;
  localparam logic [2:0] ADDR_FLAGS = 3'h5;
  localparam logic [2:0] ADDR_IRQ_EN = 3'h6;
  // timer_control_a fields
  localparam int ACT_A_POS = 6;
  localparam int ACT_B_POS = 4;
  localparam int WGM_LO_POS = 0;
  // timer_control_b fields
  localparam int FORCE_A_POS = 7;
  localparam int FORCE_B_POS = 6;
  localparam int WGM_HI_POS = 3;
  localparam int CS_POS = 0;
  // flag and enable positions
  localparam int FLAG_OVF_POS = 0;
  localparam int FLAG_A_POS = 1;
  localparam int FLAG_B_POS = 2;
  // reset values and fixed counts
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [2:0] CS_STOPPED = 3'h0;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // waveform modes
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PC_MAX = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_PC_CMP = 3'h5;
  localparam logic [2:0] WGM_FAST_CMP = 3'h7;
  // prescaler divide counts per clock select code 2..5
  localparam int DIV_8 = 8;
  localparam int DIV_64 = 64;
  localparam int DIV_256 = 256;
  localparam int DIV_1024 = 1024;
endpackage

// ### core/timer8_core.sv
// What this block does
// [RULE1] each tick clears, increments or decrements count
// [RULE2] bottom and top indications from count
// [RULE3] clock select zero stops the counter
// [RULE4] count readable and writable at any time
// [RULE5] software count write beats counting
// [RULE6] three-bit mode split across two controls
// [RULE7] comparator matches count against both channels
// [RULE8] match sets flag at the matching tick, one core clock later
// [RULE9] flag clears on service or one-write
// [RULE10] compare double buffered only in PWM
// [RULE11] access reaches buffer or active value
// [RULE12] force strobe acts like match, non-PWM
// [RULE13] count write blocks matches next tick
// [RULE14] software avoids zero load while downcounting
// [RULE15] output state survives mode changes
// [RULE16] output action bits apply immediately
// [RULE17] reset clears output states
// [RULE18] nonzero action overrides port output value
// [RULE19] action zero leaves output state alone
// [RULE20] action bits never change counting
// [RULE21] mode 0 increments and wraps
// [RULE22] overflow flag set when count wraps
// [RULE23] top is max or compare A
// [RULE24] mode 2 clears on compare A
// [RULE25] modes 3 and 7 fast PWM
// [RULE26] modes 1 and 5 phase correct PWM
// [RULE27] force ignored in PWM, reads zero
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module timer8_core (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic [2:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_EXT_CLK,
  input wire logic [2:0] I_SRV_ACK,
  input wire logic [1:0] I_PORT_VALUE,
  input wire logic [1:0] I_PIN_DIR,
  output logic [7:0] O_RDATA,
  output logic [2:0] O_IRQ,
  output logic [1:0] O_PIN_OUT,
  output logic [1:0] O_PIN_OE,
  output logic O_AT_TOP,
  output logic O_AT_BOTTOM
);
  import timer8_pkg::*;

  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] compare_reg_a;
  logic [7:0] compare_reg_b;
  logic [7:0] buf_a_reg;
  logic [7:0] buf_b_reg;
  logic [2:0] flags_reg;
  logic [2:0] flags_next;
  logic [2:0] irq_en_reg;
  logic [1:0] out_state_reg;
  logic [1:0] out_state_next;
  logic down_reg;
  logic block_reg;
  logic [9:0] pre_reg;
  logic [2:0] ext_sync_reg;
  logic [7:0] rdata_reg;

  //////////////////////////////////////////////////////////////////////
  // decode
  wire [2:0] waveform_mode_field = {ctrl_b_reg[WGM_HI_POS], ctrl_a_reg[WGM_LO_POS +: 2]}; // RULE6
  wire [2:0] clock_select_field = ctrl_b_reg[CS_POS +: 3];
  wire [1:0] act_a = ctrl_a_reg[ACT_A_POS +: 2];
  wire [1:0] act_b = ctrl_a_reg[ACT_B_POS +: 2];
  wire is_fast = (waveform_mode_field == WGM_FAST_MAX) || (waveform_mode_field == WGM_FAST_CMP);
  wire is_pc = (waveform_mode_field == WGM_PC_MAX) || (waveform_mode_field == WGM_PC_CMP);
  wire is_pwm = is_fast || is_pc;
  wire top_from_a = (waveform_mode_field == WGM_FAST_CMP) ||
                    (waveform_mode_field == WGM_PC_CMP) || (waveform_mode_field == WGM_CTC);
  wire [7:0] top_value = top_from_a ? compare_reg_a : COUNT_MAX; // RULE23
  wire at_top = (count_reg == top_value); // RULE2
  wire at_bottom = (count_reg == COUNT_BOTTOM); // RULE2
  wire wr_count = I_WR && (I_ADDR == ADDR_COUNT);
  wire wr_cmp_a = I_WR && (I_ADDR == ADDR_CMP_A);
  wire wr_cmp_b = I_WR && (I_ADDR == ADDR_CMP_B);
  wire wr_flags = I_WR && (I_ADDR == ADDR_FLAGS);
  wire wr_ctrl_b = I_WR && (I_ADDR == ADDR_CTRL_B);

  //////////////////////////////////////////////////////////////////////
  // timer tick: prescaler or synchronised external edge
  wire ext_rise = ext_sync_reg[1] && !ext_sync_reg[2];
  wire ext_fall = !ext_sync_reg[1] && ext_sync_reg[2];
  logic timer_tick;
  always_comb begin
    unique case (clock_select_field)
      3'h0: timer_tick = 1'b0; // RULE3
      3'h1: timer_tick = 1'b1;
      3'h2: timer_tick = (pre_reg[2:0] == 3'h7);
      3'h3: timer_tick = (pre_reg[5:0] == 6'h3f);
      3'h4: timer_tick = (pre_reg[7:0] == 8'hff);
      3'h5: timer_tick = (pre_reg == 10'h3ff);
      3'h6: timer_tick = ext_fall;
      3'h7: timer_tick = ext_rise;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      pre_reg <= 10'h000;
      ext_sync_reg <= 3'h0;
    end else begin
      // prescaler free runs; dividers share one counter
      pre_reg <= pre_reg + 10'h001;
      ext_sync_reg <= {ext_sync_reg[1:0], I_EXT_CLK};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // counter
  wire dir_down_next = is_pc && (at_top ? 1'b1 : (at_bottom ? 1'b0 : down_reg)); // RULE26
  always_comb begin // RULE20
    count_next = count_reg;
    if (wr_count) begin
      count_next = I_WDATA; // RULE4 RULE5
    end else if (timer_tick) begin // RULE1
      if (is_pc) begin
        count_next = dir_down_next ? count_reg - 8'h01 : count_reg + 8'h01;
      end else if ((waveform_mode_field == WGM_CTC) || is_fast) begin
        count_next = at_top ? COUNT_BOTTOM : count_reg + 8'h01; // RULE24 RULE25
      end else begin
        count_next = count_reg + 8'h01; // RULE21
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // compare and output state
  // matches gated by tick and by the write block of the previous tick
  wire match_ok = timer_tick && !block_reg; // RULE13
  wire match_a = match_ok && (count_reg == compare_reg_a); // RULE7
  wire match_b = match_ok && (count_reg == compare_reg_b); // RULE7
  wire force_a = wr_ctrl_b && I_WDATA[FORCE_A_POS] && !is_pwm; // RULE12 RULE27
  wire force_b = wr_ctrl_b && I_WDATA[FORCE_B_POS] && !is_pwm; // RULE12 RULE27
  wire bottom_tick = timer_tick && at_top && is_fast;

  function automatic logic next_out(input logic cur, input logic [1:0] act, input logic hit,
                                    input logic fast_bot, input logic pc, input logic down);
    logic r;
    r = cur;
    if (hit && act != ACT_NONE) begin // RULE19
      unique case (act)
        ACT_TOGGLE: r = !cur;
        ACT_CLEAR: r = pc ? down : 1'b0;
        ACT_SET: r = pc ? !down : 1'b1;
        default: r = cur;
      endcase
    end else if (fast_bot && act[1]) begin
      // fast PWM: the wrap to bottom restores the opposite level
      r = !act[0];
    end
    return r;
  endfunction

  always_comb begin
    // action bits read live, never buffered
    out_state_next[0] = next_out(out_state_reg[0], act_a, match_a || force_a, // RULE16
                                 bottom_tick, is_pc, down_reg);
    out_state_next[1] = next_out(out_state_reg[1], act_b, match_b || force_b,
                                 bottom_tick, is_pc, down_reg);
  end

  //////////////////////////////////////////////////////////////////////
  // flags
  always_comb begin
    flags_next = flags_reg & ~I_SRV_ACK; // RULE9
    if (wr_flags) begin
      flags_next = flags_next & ~I_WDATA[2:0]; // RULE9
    end
    // set wins over clear
    if (match_a) begin
      flags_next[FLAG_A_POS] = 1'b1; // RULE8
    end
    if (match_b) begin
      flags_next[FLAG_B_POS] = 1'b1; // RULE8
    end
    if (timer_tick && !wr_count) begin
      if (is_pc ? (count_next == COUNT_BOTTOM && count_reg != COUNT_BOTTOM)
                : (is_fast ? at_top
                           : (count_reg == COUNT_MAX && count_next == COUNT_BOTTOM))) begin
        flags_next[FLAG_OVF_POS] = 1'b1; // RULE22
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register file and state
  // buffered update in PWM at top (fast) or top (phase correct) tick
  wire load_buf = is_pwm && timer_tick && at_top; // RULE10

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_a_reg <= RESET_BYTE;
      ctrl_b_reg <= RESET_BYTE;
      irq_en_reg <= 3'h0;
    end else if (I_WR && I_ADDR == ADDR_CTRL_A) begin
      ctrl_a_reg <= I_WDATA;
    end else if (wr_ctrl_b) begin
      ctrl_b_reg <= {2'b00, I_WDATA[5:0]}; // RULE27
    end else if (I_WR && I_ADDR == ADDR_IRQ_EN) begin
      irq_en_reg <= I_WDATA[2:0];
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      buf_a_reg <= RESET_BYTE;
      buf_b_reg <= RESET_BYTE;
      compare_reg_a <= RESET_BYTE;
      compare_reg_b <= RESET_BYTE;
    end else begin
      if (wr_cmp_a) begin
        buf_a_reg <= I_WDATA; // RULE11
      end
      if (wr_cmp_b) begin
        buf_b_reg <= I_WDATA; // RULE11
      end
      if (!is_pwm) begin
        compare_reg_a <= wr_cmp_a ? I_WDATA : compare_reg_a; // RULE11
        compare_reg_b <= wr_cmp_b ? I_WDATA : compare_reg_b;
      end else if (load_buf) begin
        compare_reg_a <= buf_a_reg; // RULE10
        compare_reg_b <= buf_b_reg;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      count_reg <= RESET_BYTE;
      down_reg <= 1'b0;
      block_reg <= 1'b0;
      flags_reg <= 3'h0;
      out_state_reg <= 2'b00; // RULE17
    end else begin
      count_reg <= count_next;
      if (timer_tick) begin
        down_reg <= dir_down_next;
      end
      // held until the next tick, so a stopped timer still blocks
      block_reg <= wr_count ? 1'b1 : (timer_tick ? 1'b0 : block_reg); // RULE13
      flags_reg <= flags_next;
      out_state_reg <= out_state_next; // RULE15
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read port
  logic [7:0] rd_mux;
  always_comb begin
    unique case (I_ADDR)
      ADDR_CTRL_A: rd_mux = ctrl_a_reg;
      ADDR_CTRL_B: rd_mux = ctrl_b_reg; // RULE27
      ADDR_COUNT: rd_mux = count_reg; // RULE4
      ADDR_CMP_A: rd_mux = is_pwm ? buf_a_reg : compare_reg_a; // RULE11
      ADDR_CMP_B: rd_mux = is_pwm ? buf_b_reg : compare_reg_b;
      ADDR_FLAGS: rd_mux = {5'h00, flags_reg};
      ADDR_IRQ_EN: rd_mux = {5'h00, irq_en_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= I_RD ? rd_mux : 8'h00;
    end
  end

  assign O_RDATA = rdata_reg;
  assign O_IRQ = flags_reg & irq_en_reg; // RULE8
  assign O_PIN_OUT[0] = (act_a != ACT_NONE) ? out_state_reg[0] : I_PORT_VALUE[0]; // RULE18
  assign O_PIN_OUT[1] = (act_b != ACT_NONE) ? out_state_reg[1] : I_PORT_VALUE[1]; // RULE18
  assign O_PIN_OE = I_PIN_DIR; // RULE18
  assign O_AT_TOP = at_top;
  assign O_AT_BOTTOM = at_bottom;

  //////////////////////////////////////////////////////////////////////
  // checks
  property p_stopped_hold;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (clock_select_field == CS_STOPPED && !wr_count) |=> $stable(count_reg);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold) else $error("count moved while stopped"); // RULE3

  property p_write_wins;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      wr_count |=> (count_reg == $past(I_WDATA));
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("count write lost"); // RULE5

  property p_normal_inc;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (timer_tick && !wr_count && waveform_mode_field == WGM_NORMAL)
        |=> (count_reg == $past(count_reg) + 8'h01);
  endproperty
  a_normal_inc: assert property (p_normal_inc) else $error("normal mode miscount"); // RULE21

  property p_match_flag;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      match_a |=> flags_reg[FLAG_A_POS];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag not set"); // RULE8

  // helper: a count write stays pending until the next tick, however long that takes
  logic wr_pending_chk;
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      wr_pending_chk <= 1'b0;
    end else if (wr_count) begin
      wr_pending_chk <= 1'b1;
    end else if (timer_tick) begin
      wr_pending_chk <= 1'b0;
    end
  end

  sequence s_count_write;
    wr_pending_chk && timer_tick;
  endsequence
  property p_block;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      s_count_write |=> !$rose(flags_reg[FLAG_A_POS]) && !$rose(flags_reg[FLAG_B_POS]);
  endproperty
  a_block: assert property (p_block) else $error("match after count write"); // RULE13

  property p_ctc_clear;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (timer_tick && !wr_count && waveform_mode_field == WGM_CTC && at_top)
        |=> (count_reg == COUNT_BOTTOM);
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("ctc did not clear"); // RULE24

  property p_no_action;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (act_a == ACT_NONE && !is_fast) |=> $stable(out_state_reg[0]);
  endproperty
  a_no_action: assert property (p_no_action) else $error("output moved with no action"); // RULE19

  property p_overflow;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (timer_tick && !wr_count && waveform_mode_field == WGM_NORMAL && count_reg == COUNT_MAX)
        |=> flags_reg[FLAG_OVF_POS] && count_reg == COUNT_BOTTOM;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow flag not set"); // RULE22

  property p_force_pwm;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (wr_ctrl_b && is_pwm && !timer_tick) |=> $stable(out_state_reg);
  endproperty
  a_force_pwm: assert property (p_force_pwm) else $error("force acted in pwm"); // RULE27

  property p_buffer_hold;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (is_pwm && !load_buf) |=> $stable(compare_reg_a) && $stable(compare_reg_b);
  endproperty
  a_buffer_hold: assert property (p_buffer_hold) else $error("active compare moved"); // RULE10

  property p_direct_write;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (wr_cmp_a && !is_pwm) |=> (compare_reg_a == $past(I_WDATA));
  endproperty
  a_direct_write: assert property (p_direct_write) else $error("compare write lost"); // RULE11

  property p_pc_turn;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (timer_tick && !wr_count && is_pc && at_top && !at_bottom)
        |=> (count_reg == $past(count_reg) - 8'h01);
  endproperty
  a_pc_turn: assert property (p_pc_turn) else $error("no turn at top"); // RULE26

  property p_fast_wrap;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (timer_tick && !wr_count && is_fast && at_top) |=> (count_reg == COUNT_BOTTOM);
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("fast mode did not wrap"); // RULE25
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  import timer8_pkg::*;
  logic I_CORE_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic [2:0] I_ADDR = 3'h0;
  logic [7:0] I_WDATA = 8'h00;
  logic I_WR = 1'b0;
  logic I_RD = 1'b0;
  logic I_EXT_CLK = 1'b0;
  logic [2:0] I_SRV_ACK = 3'h0;
  logic [1:0] I_PORT_VALUE = 2'h0;
  logic [1:0] I_PIN_DIR = 2'h0;
  logic [7:0] O_RDATA;
  logic [2:0] O_IRQ;
  logic [1:0] O_PIN_OUT;
  logic [1:0] O_PIN_OE;
  logic O_AT_TOP;
  logic O_AT_BOTTOM;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] expq[$];
  logic rd_seen = 1'b0;
  logic [31:0] rs = 32'd92592;
  logic [1:0] acts[4] = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_TOGGLE};
  logic st_exp[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  // over 64 enabled edges every one of these selects ticks an exact number of times
  logic [2:0] cs_sel[4] = '{3'h2, 3'h3, 3'h6, 3'h7};
  logic [7:0] cs_cnt[4] = '{8'h08, 8'h01, 8'h20, 8'h20};

  timer8_core dut_u (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_EXT_CLK(I_EXT_CLK),
    .I_SRV_ACK(I_SRV_ACK), .I_PORT_VALUE(I_PORT_VALUE), .I_PIN_DIR(I_PIN_DIR),
    .O_RDATA(O_RDATA), .O_IRQ(O_IRQ), .O_PIN_OUT(O_PIN_OUT), .O_PIN_OE(O_PIN_OE),
    .O_AT_TOP(O_AT_TOP), .O_AT_BOTTOM(O_AT_BOTTOM));

  always #5 I_CORE_CLK = ~I_CORE_CLK;

  function logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // read data stands only in the cycle after the strobe, so sample mid-cycle
  always @(posedge I_CORE_CLK) begin
    rd_seen <= I_RD;
    I_EXT_CLK <= ~I_EXT_CLK;
    cyc = cyc + 1;
    if (cyc > 8000) begin
      errors++;
      $display("BAD timeout exp %h got %h", 0, cyc);
      tally_and_finish();
    end
  end
  always @(negedge I_CORE_CLK) begin
    if (rd_seen) begin
      logic [7:0] e;
      e = expq.pop_front();
      `CHK("rdata", e, O_RDATA)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge I_CORE_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CORE_CLK);
    I_WR <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge I_CORE_CLK);
    expq.push_back(e);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CORE_CLK);
    I_RD <= 1'b0;
  endtask
  task automatic run(input int n);
    wr(ADDR_CTRL_B, 8'h01);
    repeat (n) @(posedge I_CORE_CLK);
    wr(ADDR_CTRL_B, 8'h00);
  endtask
  task automatic settle();
    repeat (2) @(posedge I_CORE_CLK);
    @(negedge I_CORE_CLK);
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    logic [1:0] pe;
    int sh;
    int fb;
    repeat (5) @(posedge I_CORE_CLK);
    I_RST <= 1'b0;
    I_PORT_VALUE <= 2'(xs());
    I_PIN_DIR <= 2'(xs());
    @(negedge I_CORE_CLK);
    `CHK("pin_out", I_PORT_VALUE, O_PIN_OUT)
    `CHK("pin_oe", I_PIN_DIR, O_PIN_OE)
    `CHK("bottom", 1'b1, O_AT_BOTTOM)
    for (int a = 0; a < 8; a++)
      rd(3'(a), 8'h00);
    wr(3'h7, 8'hff);
    rd(3'h7, 8'h00);
    tdone("reset");
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_CTRL_A, 8'(m[1:0]));
      wr(ADDR_CTRL_B, 8'(m[2]) << WGM_HI_POS);
      rd(ADDR_CTRL_A, 8'(m[1:0]));
      rd(ADDR_CTRL_B, 8'(m[2]) << WGM_HI_POS);
    end
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_CTRL_B, 8'h00);
    repeat (6) begin
      v = 8'(xs());
      wr(ADDR_COUNT, v);
      repeat (3) @(posedge I_CORE_CLK);
      rd(ADDR_COUNT, v);
    end
    tdone("stopped count");
    // overflow in normal mode, cleared by service pulse
    wr(ADDR_CMP_A, 8'h80);
    wr(ADDR_CMP_B, 8'h81);
    wr(ADDR_IRQ_EN, 8'h07);
    wr(ADDR_COUNT, COUNT_MAX);
    settle();
    `CHK("top", 1'b1, O_AT_TOP)
    wr(ADDR_COUNT, 8'hfc);
    run(12);
    rd(ADDR_FLAGS, 8'h01);
    @(negedge I_CORE_CLK);
    `CHK("irq", 3'b001, O_IRQ)
    @(posedge I_CORE_CLK);
    I_SRV_ACK <= 3'b001;
    @(posedge I_CORE_CLK);
    I_SRV_ACK <= 3'b000;
    @(negedge I_CORE_CLK);
    `CHK("irq", 3'b000, O_IRQ)
    tdone("overflow");
    // both channels match; partial clear by one-write, then by service
    wr(ADDR_COUNT, 8'h40);
    wr(ADDR_CMP_A, 8'h42);
    wr(ADDR_CMP_B, 8'h44);
    run(12);
    rd(ADDR_FLAGS, 8'h06);
    wr(ADDR_FLAGS, 8'h02);
    rd(ADDR_FLAGS, 8'h04);
    @(posedge I_CORE_CLK);
    I_SRV_ACK <= 3'b100;
    @(posedge I_CORE_CLK);
    I_SRV_ACK <= 3'b000;
    rd(ADDR_FLAGS, 8'h00);
    // count loaded equal to compare must not match on the first tick
    wr(ADDR_CMP_A, 8'h50);
    wr(ADDR_COUNT, 8'h50);
    run(6);
    rd(ADDR_FLAGS, 8'h00);
    tdone("match");
    // force strobes in normal mode, per channel
    wr(ADDR_COUNT, 8'h5a);
    for (int ch = 0; ch < 2; ch++) begin
      sh = ch ? ACT_B_POS : ACT_A_POS;
      fb = ch ? FORCE_B_POS : FORCE_A_POS;
      for (int i = 0; i < 4; i++) begin
        wr(ADDR_CTRL_A, 8'(acts[i]) << sh);
        wr(ADDR_CTRL_B, 8'h01 << fb);
        settle();
        pe = I_PORT_VALUE;
        pe[ch] = st_exp[i];
        `CHK("force_pin", pe, O_PIN_OUT)
      end
      wr(ADDR_CTRL_A, 8'h00);
      wr(ADDR_CTRL_B, 8'h01 << fb);
      settle();
      `CHK("port_pin", I_PORT_VALUE, O_PIN_OUT)
      wr(ADDR_CTRL_A, 8'(ACT_TOGGLE) << sh);
      settle();
      pe = I_PORT_VALUE;
      pe[ch] = 1'b0;
      `CHK("idle_pin", pe, O_PIN_OUT)
    end
    rd(ADDR_FLAGS, 8'h00);
    rd(ADDR_CTRL_B, 8'h00);
    rd(ADDR_COUNT, 8'h5a);
    // state survives mode change; force ignored under PWM
    wr(ADDR_CTRL_A, 8'(ACT_SET) << ACT_A_POS);
    wr(ADDR_CTRL_B, 8'h01 << FORCE_A_POS);
    wr(ADDR_CTRL_A, (8'(ACT_CLEAR) << ACT_A_POS) | 8'(WGM_FAST_MAX));
    wr(ADDR_CTRL_B, 8'h01 << FORCE_A_POS);
    settle();
    `CHK("pwm_pin", 1'b1, O_PIN_OUT[0])
    wr(ADDR_CTRL_A, 8'(ACT_CLEAR) << ACT_A_POS);
    settle();
    `CHK("mode_pin", 1'b1, O_PIN_OUT[0])
    // prescaled and external ticks; action A off keeps the output state for later
    wr(ADDR_CTRL_A, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_CTRL_B, 8'(cs_sel[k]));
      repeat (62) @(posedge I_CORE_CLK);
      wr(ADDR_CTRL_B, 8'h00);
      rd(ADDR_COUNT, cs_cnt[k]);
    end
    tdone("force");
    // clear-on-match: never wraps, so no overflow and no B match
    wr(ADDR_CTRL_A, 8'(WGM_CTC));
    wr(ADDR_CMP_A, 8'h05);
    wr(ADDR_COUNT, 8'h05);
    settle();
    `CHK("ctc_top", 1'b1, O_AT_TOP)
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_FLAGS, 8'h07);
    run(300);
    rd(ADDR_FLAGS, 8'h02);
    tdone("ctc");
    // phase correct: buffered compare B stays 0x44 until top
    wr(ADDR_CTRL_A, 8'(WGM_PC_MAX));
    wr(ADDR_CMP_B, 8'h20);
    rd(ADDR_CMP_B, 8'h20);
    wr(ADDR_COUNT, 8'h21);
    wr(ADDR_FLAGS, 8'h07);
    run(300);
    rd(ADDR_FLAGS, 8'h04);
    // fast PWM wraps at max and sees the loaded compare B
    wr(ADDR_CTRL_A, 8'(WGM_FAST_MAX));
    wr(ADDR_COUNT, 8'h21);
    wr(ADDR_FLAGS, 8'h07);
    run(300);
    rd(ADDR_FLAGS, 8'h07);
    // mode 7: top is compare A (0x05), so 64 ticks end on count 4
    wr(ADDR_CTRL_A, 8'h03);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_CTRL_B, 8'h09);
    repeat (62) @(posedge I_CORE_CLK);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_COUNT, 8'h04);
    rd(ADDR_FLAGS, 8'h03);
    tdone("pwm");
    // second reset clears the output state
    @(posedge I_CORE_CLK);
    I_RST <= 1'b1;
    repeat (5) @(posedge I_CORE_CLK);
    I_RST <= 1'b0;
    wr(ADDR_CTRL_A, 8'(ACT_TOGGLE) << ACT_A_POS);
    settle();
    `CHK("rst_pin", 1'b0, O_PIN_OUT[0])
    tdone("rereset");
    repeat (3) @(posedge I_CORE_CLK);
    tally_and_finish();
  end
endmodule
